// ==== cassette_ctrl.sv ====
// Summary of operation
// - Separate read and write byte registers
// - Write byte loads on strobe, held
// - Write byte output blocked outside transfer
// - Function table from function bits, repeat
// - Status table gives repeat, go, error
// - Go fires pulse A, clears ready
// - Pulse B start may set repeat
// - Pulse C start sets ready unless go-enable
// - Ready raises interrupt condition
// - Pulse C end sets start
// - Write start sets byte request; access clears
// - Delayed transfer request sets transfer flag
// - Transfer end sets byte request again
// - Last-byte bit clears byte request
// - Read fills buffer from tape first
// - Repeat blocks ready, forces address bit3
// - Transport ready clears repeat, retriggers C
// - Bus request from enabled interrupt, idle
// - Grant sets grant and select-ack
// - Bus busy after lines released
// - Bus busy drives vector and interrupt
// - Go is control bit 0 with write
// - Data transfers use low byte only
`timescale 1ns/1ps
module cassette_ctrl #(
  parameter logic [15:0] VECTOR_ADDR = cassette_pkg::VECTOR_DEFAULT
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        bus_initialize_n,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [4:0]  tape_status,
  input  wire logic        tape_ready,
  input  wire logic        tape_xfer_req,
  input  wire logic [7:0]  tape_rd_data,
  output logic             tape_start,
  output logic      [7:0]  tape_function,
  output logic             tape_transfer,
  output logic      [7:0]  tape_wr_data,
  output logic             bus_request_out,
  input  wire logic        grant_in,
  input  wire logic        bus_busy_in,
  input  wire logic        slave_sync_in,
  output logic             bus_busy_out,
  output logic             bus_interrupt_line,
  output logic      [15:0] vector_data,
  output logic             vector_oe_n
);
  import cassette_pkg::*;

  ctl_st_t q;
  ctl_st_t d;

  delay_if dly ();

  logic        sel_ctrl;
  logic        sel_data;
  logic        acc_done;
  logic        wr_done;
  logic        go;
  logic        wbuf_load_strobe;
  logic        buffer_select;
  logic [3:0]  fn_addr;
  logic [7:0]  fn;
  logic        write_mode;
  logic        read_mode;
  logic [7:0]  st_addr;
  logic [3:0]  sr;
  logic        repeat_enable;
  logic        go_enable;
  logic        rdy_rise;
  logic        rdy_fall;
  logic        xreq_rise;
  logic        gnt_rise;
  logic        interrupt_condition;
  logic        wbuf_output_block;
  logic        ready_set;
  logic [31:0] rd_ctrl;

  // ==========================================================
  // Decode and lookup tables
  always_comb begin
    sel_ctrl         = (avs_address == CTRL_OFS);
    sel_data         = (avs_address == DATA_OFS);
    acc_done         = (avs_read || avs_write) && !q.waitreq;
    wr_done          = avs_write && !q.waitreq;
    go               = wr_done && sel_ctrl && avs_byteenable[0] && avs_writedata[GO_BIT];
    wbuf_load_strobe = wr_done && sel_data && avs_byteenable[0];
    buffer_select    = acc_done && sel_data;
    fn_addr          = {q.repeat_flag, q.func};
    fn               = FUNC_ROM[fn_addr];
    write_mode       = fn[FN_WRITE_BIT];
    read_mode        = fn[FN_FWD_BIT] && !fn[FN_WRITE_BIT];
    st_addr          = {tape_status, q.func};
    sr               = STAT_ROM[st_addr[4:0]];
    repeat_enable    = sr[SR_REPEAT];
    go_enable        = sr[SR_GO];
    ready_set        = !go_enable && !q.repeat_flag;
    rdy_rise         = tape_ready && !q.rdy_prev;
    rdy_fall         = !tape_ready && q.rdy_prev;
    xreq_rise        = tape_xfer_req && !q.xreq_prev;
    gnt_rise         = grant_in && !q.gnt_prev;
    interrupt_condition = q.ready && !q.served;
    wbuf_output_block   = !(q.xfer && write_mode);
    rd_ctrl                 = 32'h0000_0000;
    rd_ctrl[FUNC_LSB +: 3]  = q.func;
    rd_ctrl[LAST_BIT]       = q.last;
    rd_ctrl[BREQ_BIT]       = q.breq;
    rd_ctrl[IE_BIT]         = q.ie;
    rd_ctrl[RDY_BIT]        = q.ready;
    rd_ctrl[UNIT_BIT]       = q.unit;
    rd_ctrl[ERR_BIT]        = sr[SR_ERROR];
  end

  assign dly.start = xreq_rise;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    // Bus slave: one wait cycle, then a single ready cycle
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      if (sel_ctrl) begin
        d.rdata = rd_ctrl;
      end else if (sel_data) begin
        d.rdata = {24'h00_0000, q.rbuf};
      end else begin
        d.rdata = 32'h0000_0000;
      end
    end
    if (wr_done && sel_ctrl) begin
      if (avs_byteenable[0]) begin
        d.func = avs_writedata[FUNC_LSB +: 3];
        d.last = avs_writedata[LAST_BIT];
        d.ie   = avs_writedata[IE_BIT];
      end
      if (avs_byteenable[1]) begin
        d.unit = avs_writedata[UNIT_BIT];
      end
    end
    if (wbuf_load_strobe) begin
      d.wbuf = avs_writedata[7:0];
    end
    // Clears first so that a set in the same cycle wins
    if (buffer_select) begin
      d.breq = 1'b0;
    end
    if (wr_done && sel_ctrl && avs_byteenable[0] && avs_writedata[LAST_BIT]) begin
      d.breq = 1'b0;
    end

    // Transport handshakes
    d.rdy_prev  = tape_ready;
    d.xreq_prev = tape_xfer_req;
    if (rdy_fall) begin
      d.start = 1'b0;
    end
    if (rdy_rise && (q.seq == SEQ_IDLE)) begin
      if (q.repeat_flag) begin
        d.repeat_flag = 1'b0;
        d.seq         = SEQ_C;
        d.cnt         = 8'(PULSE_C_CYC);
        d.start       = 1'b0;
      end else begin
        d.ready = 1'b1;
      end
    end
    // Last byte already answered: no further transfers
    if (dly.done && !q.breq && !q.last) begin
      d.xfer = 1'b1;
      if (read_mode) begin
        d.rbuf = tape_rd_data;
      end
    end
    if (q.xfer && !tape_xfer_req) begin
      d.xfer = 1'b0;
      d.breq = 1'b1;
    end

    // One-shot chain A, B, C as cycle counters
    case (q.seq)
      SEQ_IDLE: begin
        if (go) begin
          d.seq   = SEQ_A;
          d.cnt   = 8'(PULSE_A_CYC);
          d.ready = 1'b0;
          d.last  = 1'b0;
        end
      end
      SEQ_A: begin
        if (q.cnt == CNT_ONE) begin
          d.seq = SEQ_B;
          d.cnt = 8'(PULSE_B_CYC);
          if (repeat_enable) begin
            d.repeat_flag = 1'b1;
          end
        end else begin
          d.cnt = q.cnt - CNT_ONE;
        end
      end
      SEQ_B: begin
        if (q.cnt == CNT_ONE) begin
          d.seq   = SEQ_C;
          d.cnt   = 8'(PULSE_C_CYC);
          d.ready = ready_set;
        end else begin
          d.cnt = q.cnt - CNT_ONE;
        end
      end
      SEQ_C: begin
        if (q.cnt == CNT_ONE) begin
          d.seq   = SEQ_IDLE;
          d.start = 1'b1;
          if (write_mode) begin
            d.breq = 1'b1;
          end
        end else begin
          d.cnt = q.cnt - CNT_ONE;
        end
      end
      default: begin
        d.seq = SEQ_IDLE;
      end
    endcase

    // Bus mastership for the interrupt
    d.gnt_prev = grant_in;
    if (gnt_rise && q.req_out) begin
      d.grant              = 1'b1;
      d.selection_ack_flag = 1'b1;
    end
    if (q.selection_ack_flag && !q.bus_busy_flag && !bus_busy_in && !slave_sync_in && !grant_in) begin
      d.bus_busy_flag = 1'b1;
    end
    // Vector taken once the processor answers with slave sync
    if (q.bus_busy_flag && slave_sync_in) begin
      d.bus_busy_flag      = 1'b0;
      d.selection_ack_flag = 1'b0;
      d.grant              = 1'b0;
      d.served             = 1'b1;
    end
    if (!d.ready) begin
      d.served = 1'b0;
    end

    if (!bus_initialize_n) begin
      d.seq         = SEQ_IDLE;
      d.ready       = 1'b0;
      d.repeat_flag = 1'b0;
      d.start       = 1'b0;
      d.breq        = 1'b0;
      d.xfer        = 1'b0;
      d.grant       = 1'b0;
      d.selection_ack_flag = 1'b0;
      d.bus_busy_flag      = 1'b0;
      d.served      = 1'b0;
      d.wbuf        = 8'h00;
    end

    // Registered pin images
    d.fn_out   = fn;
    d.wr_out   = wbuf_output_block ? 8'h00 : q.wbuf;
    d.req_out  = interrupt_condition && q.ie && !q.selection_ack_flag && !q.bus_busy_flag;
    d.intr_out = d.bus_busy_flag;
    d.vec      = d.bus_busy_flag ? VECTOR_ADDR : 16'h0000;
    d.vec_oe_n = !d.bus_busy_flag;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  xfer_delay u_xfer_delay (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .clear    (!bus_initialize_n),
    .lnk      (dly.timer)
  );

  // ==========================================================
  // Outputs
  assign avs_readdata       = q.rdata;
  assign avs_waitrequest    = q.waitreq;
  assign tape_start         = q.start;
  assign tape_function      = q.fn_out;
  assign tape_transfer      = q.xfer;
  assign tape_wr_data       = q.wr_out;
  assign bus_request_out    = q.req_out;
  assign bus_busy_out       = q.bus_busy_flag;
  assign bus_interrupt_line = q.intr_out;
  assign vector_data        = q.vec;
  assign vector_oe_n        = q.vec_oe_n;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n || !bus_initialize_n);

  sequence s_enter_a;
    $rose(q.seq == SEQ_A);
  endsequence

  sequence s_enter_c;
    $rose(q.seq == SEQ_C);
  endsequence

  a_go_clears_ready: assert property (
    (go && q.seq == SEQ_IDLE) |=> (!q.ready && q.seq == SEQ_A))
    else $error("go did not start pulse A");

  a_pulse_a_len: assert property (
    s_enter_a |-> ##20 (q.seq == SEQ_B))
    else $error("pulse A not 1 us");

  a_c_to_start: assert property (
    s_enter_c |-> ##40 (q.start && q.seq == SEQ_IDLE))
    else $error("start not set after pulse C");

  a_ready_at_c: assert property (
    ($rose(q.seq == SEQ_C) && $past(q.seq == SEQ_B)) |-> (q.ready == $past(ready_set)))
    else $error("ready wrong at pulse C");

  a_req_blocked: assert property (
    (q.selection_ack_flag || q.bus_busy_flag) |=> !q.req_out)
    else $error("request while master");

  a_grant_sets_ack: assert property (
    (gnt_rise && q.req_out) |=> (q.selection_ack_flag && q.grant))
    else $error("grant did not set select-ack");

  a_busy_after_release: assert property (
    $rose(q.bus_busy_flag) |-> $past(q.selection_ack_flag && !bus_busy_in && !slave_sync_in && !grant_in))
    else $error("bus busy taken too early");

  a_busy_drives_vector: assert property (
    q.bus_busy_flag |-> (q.intr_out && !q.vec_oe_n && q.vec == VECTOR_ADDR))
    else $error("vector not driven");

  a_xfer_needs_idle: assert property (
    $rose(q.xfer) |-> $past(dly.done && !q.breq))
    else $error("transfer set while byte pending");

  a_wbuf_blocked: assert property (
    !(q.xfer && write_mode) |=> (q.wr_out == 8'h00))
    else $error("write byte leaked");

  a_wbuf_hold: assert property (
    (!wbuf_load_strobe && bus_initialize_n) |=> $stable(q.wbuf))
    else $error("write byte changed without strobe");
endmodule // cassette_ctrl

// ==== cassette_ctrl_tb.sv ====
`timescale 1ns/1ps
module cassette_ctrl_tb;
  import cassette_pkg::*;
  // ==========================================
  // Signals
  logic        core_clk         = 1'b0;
  logic        arst_n           = 1'b0;
  logic        bus_initialize_n = 1'b1;
  logic [2:0]  avs_address      = 3'h0;
  logic        avs_read         = 1'b0;
  logic        avs_write        = 1'b0;
  logic [31:0] avs_writedata    = 32'h0;
  logic [3:0]  avs_byteenable   = 4'h3;
  logic [4:0]  tape_status      = 5'h01;
  logic        grant_in         = 1'b0;
  logic        bus_busy_in      = 1'b0;
  logic        slave_sync_in    = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tape_ready, tape_xfer_req, tape_start, tape_transfer;
  logic [7:0]  tape_rd_data, tape_function, tape_wr_data;
  logic        bus_request_out, bus_busy_out, bus_interrupt_line, vector_oe_n;
  logic [15:0] vector_data;
  int          errors           = 0;
  int          check_count      = 0;
  int          cycles           = 0;
  int          n;
  logic [31:0] rd;
  logic        got;
  logic [7:0]  wr;
  logic [7:0]  fn_tab [8]       = '{8'h05, 8'h61, 8'h20, 8'h10, 8'h08, 8'h04, 8'h00, 8'h02};

  always #25 core_clk = ~core_clk;

  cassette_ctrl dut (
    .core_clk(core_clk), .arst_n(arst_n), .bus_initialize_n(bus_initialize_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tape_status(tape_status), .tape_ready(tape_ready),
    .tape_xfer_req(tape_xfer_req), .tape_rd_data(tape_rd_data), .tape_start(tape_start),
    .tape_function(tape_function), .tape_transfer(tape_transfer), .tape_wr_data(tape_wr_data),
    .bus_request_out(bus_request_out), .grant_in(grant_in), .bus_busy_in(bus_busy_in),
    .slave_sync_in(slave_sync_in), .bus_busy_out(bus_busy_out), .bus_interrupt_line(bus_interrupt_line),
    .vector_data(vector_data), .vector_oe_n(vector_oe_n)
  );

  tape_transport_model model (
    .core_clk(core_clk), .tape_transfer(tape_transfer), .tape_wr_data(tape_wr_data),
    .tape_ready(tape_ready), .tape_xfer_req(tape_xfer_req), .tape_rd_data(tape_rd_data)
  );

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  // A lost answer is ended by the hang guard only
  task automatic bus_op(input logic wr_en, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr_en;
    avs_read      <= ~wr_en;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wctl(input logic [7:0] v);
    bus_op(1'b1, CTRL_OFS, {24'h0, v});
  endtask

  task automatic rctl(input string what, input int b, input logic exp);
    bus_op(1'b0, CTRL_OFS, 32'h0);
    check(what, {31'h0, rd[b]}, {31'h0, exp});
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = tape_start;
      1: pick = bus_request_out;
      default: pick = bus_busy_out;
    endcase
  endfunction

  task automatic wait_for(input int sel, output int k);
    k = 0;
    while (pick(sel) !== 1'b1 && k < 200) begin
      @(posedge core_clk);
      k++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far above the several hundred cycles needed
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================
  // Tests
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    check("waitrequest idle", avs_waitrequest, 1'b1);
    check("vector enable idle", vector_oe_n, 1'b1);
    rctl("ready after reset", RDY_BIT, 1'b0);
    bus_op(1'b0, 3'h2, 32'h0);
    check("unmapped read", rd, 32'h0);
    for (int f = 0; f < 8; f++) begin
      wctl({4'h0, f[2:0], 1'b0});
      repeat (2) @(posedge core_clk);
      check("function word", tape_function, fn_tab[f]);
    end
    $display("test function table done");

    // Gap write at status where no go-enable, then interrupt cycle
    wctl(8'h41);
    wait_for(0, n);
    check("start delay", (n >= 78 && n <= 86), 1'b1);
    check("gap function", tape_function, 8'h05);
    wait_for(1, n);
    check("bus request", bus_request_out, 1'b1);
    check("busy before grant", bus_busy_out, 1'b0);
    grant_in    <= 1'b1;
    bus_busy_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("request after grant", bus_request_out, 1'b0);
    check("busy while held", bus_busy_out, 1'b0);
    grant_in    <= 1'b0;
    bus_busy_in <= 1'b0;
    wait_for(2, n);
    check("busy after release", (n <= 4), 1'b1);
    check("interrupt line", bus_interrupt_line, 1'b1);
    check("vector", vector_data, VECTOR_DEFAULT);
    check("vector enable", vector_oe_n, 1'b0);
    slave_sync_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    slave_sync_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("busy dropped", bus_busy_out, 1'b0);
    model.end_block();
    check("start after stop", tape_start, 1'b0);
    rctl("ready kept", RDY_BIT, 1'b1);
    $display("test gap and interrupt done");

    // Plain write
    wctl(8'h03);
    rctl("ready at go", RDY_BIT, 1'b0);
    wait_for(0, n);
    check("write function", tape_function, 8'h61);
    rctl("ready go enable", RDY_BIT, 1'b0);
    rctl("request at start", BREQ_BIT, 1'b1);
    model.byte_xfer(8'h11, got, wr);
    check("transfer refused", got, 1'b0);
    bus_op(1'b1, DATA_OFS, 32'h1234_56a5);
    check("blocked byte", tape_wr_data, 8'h00);
    rctl("request after load", BREQ_BIT, 1'b0);
    model.byte_xfer(8'h11, got, wr);
    check("transfer taken", got, 1'b1);
    check("written byte", wr, 8'ha5);
    rctl("next request", BREQ_BIT, 1'b1);
    wctl(8'h12);
    rctl("request after last", BREQ_BIT, 1'b0);
    model.end_block();
    $display("test write done");

    // Read
    wctl(8'h05);
    wait_for(0, n);
    check("read function", tape_function, 8'h20);
    rctl("no request at read", BREQ_BIT, 1'b0);
    model.byte_xfer(8'h96, got, wr);
    check("read transfer", got, 1'b1);
    rctl("read request", BREQ_BIT, 1'b1);
    bus_op(1'b0, DATA_OFS, 32'h0);
    check("read byte", rd, 32'h0000_0096);
    rctl("request after read", BREQ_BIT, 1'b0);
    model.end_block();
    $display("test read done");

    // Write at tape start: gap first, then write
    tape_status <= 5'h03;
    wctl(8'h03);
    wait_for(0, n);
    check("repeat function", tape_function, 8'h05);
    rctl("ready held", RDY_BIT, 1'b0);
    model.end_block();
    wait_for(0, n);
    check("retrigger delay", (n <= 45), 1'b1);
    check("restored function", tape_function, 8'h61);
    rctl("ready stays clear", RDY_BIT, 1'b0);
    bus_initialize_n <= 1'b0;
    @(posedge core_clk);
    bus_initialize_n <= 1'b1;
    @(posedge core_clk);
    @(posedge core_clk);
    check("start cleared", tape_start, 1'b0);
    rctl("request cleared", BREQ_BIT, 1'b0);
    check("write byte cleared", tape_wr_data, 8'h00);
    model.byte_xfer(8'h3c, got, wr);
    check("transfer after init", got, 1'b1);
    check("cleared byte sent", wr, 8'h00);
    $display("test tape start write done");
    final_report();
  end
endmodule // cassette_ctrl_tb

// ==== cassette_pkg.sv ====
package cassette_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PULSE_A_NS    = 1000;
  localparam int PULSE_B_NS    = 1000;
  localparam int PULSE_C_NS    = 2000;
  localparam int XFER_DLY_NS   = 2000;
  localparam int PULSE_A_CYC   = (PULSE_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_B_CYC   = (PULSE_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_C_CYC   = (PULSE_C_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XFER_DLY_CYC  = (XFER_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // ==========================================================
  // Register map and fields
  localparam logic [2:0] CTRL_OFS = 3'h0;
  localparam logic [2:0] DATA_OFS = 3'h4;
  localparam int GO_BIT   = 0;
  localparam int FUNC_LSB = 1;
  localparam int LAST_BIT = 4;
  localparam int BREQ_BIT = 5;
  localparam int IE_BIT   = 6;
  localparam int RDY_BIT  = 7;
  localparam int UNIT_BIT = 8;
  localparam int ERR_BIT  = 15;
  localparam logic [15:0] VECTOR_DEFAULT = 16'h00c0;

  // ==========================================================
  // Lookup tables
  localparam int FN_WRITE_BIT = 6;
  localparam int FN_FWD_BIT   = 5;
  localparam int SR_REPEAT    = 0;
  localparam int SR_ACTION    = 1;
  localparam int SR_ERROR     = 2;
  localparam int SR_GO        = 3;
  // Index 15 first; only the low 16 words are reachable
  localparam logic [15:0][7:0] FUNC_ROM = {
    {6{8'h00}}, 8'h05, 8'h00,
    8'h02, 8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h61, 8'h05};
  // Low 32 words; upper words alias onto these
  localparam logic [31:0][3:0] STAT_ROM = {
    {5{4'h2}}, 4'ha, 4'h9, 4'h9, {8{4'h8}},
    {5{4'h2}}, 4'ha, 4'ha, 4'h2, {8{4'h8}}};

  // ==========================================================
  // State
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_A    = 4'h2,
    SEQ_B    = 4'h4,
    SEQ_C    = 4'h8
  } seq_t;

  typedef struct packed {
    seq_t        seq;
    logic [7:0]  cnt;
    logic        ready;
    logic        repeat_flag;
    logic        start;
    logic        breq;
    logic        xfer;
    logic        grant;
    logic        selection_ack_flag;
    logic        bus_busy_flag;
    logic        served;
    logic [2:0]  func;
    logic        unit;
    logic        ie;
    logic        last;
    logic [7:0]  wbuf;
    logic [7:0]  rbuf;
    logic        waitreq;
    logic [31:0] rdata;
    logic        rdy_prev;
    logic        xreq_prev;
    logic        gnt_prev;
    logic [7:0]  fn_out;
    logic [7:0]  wr_out;
    logic        req_out;
    logic        intr_out;
    logic [15:0] vec;
    logic        vec_oe_n;
  } ctl_st_t;

  // Ready image starts high, its idle level, so reset gives no false rise
  localparam ctl_st_t CTL_RESET = '{seq: SEQ_IDLE, waitreq: 1'b1, vec_oe_n: 1'b1, rdy_prev: 1'b1, default: '0};

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] cnt;
  } tmr_st_t;

  localparam tmr_st_t TMR_RESET = '0;
endpackage

// ==== delay_if.sv ====
`timescale 1ns/1ps
interface delay_if;
  logic start;
  logic done;
  modport timer (input start, output done);
  modport user (output start, input done);
endinterface

// ==== tape_transport_model.sv ====
`timescale 1ns/1ps
module tape_transport_model (
  input  wire logic       core_clk,
  input  wire logic       tape_transfer,
  input  wire logic [7:0] tape_wr_data,
  output logic            tape_ready,
  output logic            tape_xfer_req,
  output logic      [7:0] tape_rd_data
);
  // ==========================================
  // Idle transport: ready, no request
  initial begin
    tape_ready    = 1'b1;
    tape_xfer_req = 1'b0;
    tape_rd_data  = 8'hff;
  end

  // ==========================================
  // One byte handshake, read byte offered meanwhile
  task automatic byte_xfer(input logic [7:0] rd_byte, output logic got, output logic [7:0] wr_byte);
    int n;
    n = 0;
    @(posedge core_clk);
    tape_xfer_req <= 1'b1;
    tape_rd_data  <= rd_byte;
    while (tape_transfer !== 1'b1 && n < 80) begin
      @(posedge core_clk);
      n++;
    end
    got = (tape_transfer === 1'b1);
    repeat (2) @(posedge core_clk);
    wr_byte = tape_wr_data;
    tape_xfer_req <= 1'b0;
    // Released lines show no stale byte
    tape_rd_data  <= ~rd_byte;
  endtask

  // ==========================================
  // Block done: stop and drop ready a while
  task automatic end_block();
    repeat (10) @(posedge core_clk);
    tape_ready <= 1'b0;
    repeat (10) @(posedge core_clk);
    tape_ready <= 1'b1;
    @(posedge core_clk);
  endtask
endmodule // tape_transport_model

// ==== xfer_delay.sv ====
`timescale 1ns/1ps
module xfer_delay (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clear,
  delay_if.timer   lnk
);
  import cassette_pkg::*;

  tmr_st_t q;
  tmr_st_t d;

  // ==========================================================
  // Retriggering is ignored while the delay runs
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (clear) begin
      d = TMR_RESET;
    end else if (q.busy) begin
      if (q.cnt == CNT_ONE) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - CNT_ONE;
      end
    end else if (lnk.start) begin
      d.busy = 1'b1;
      d.cnt  = 8'(XFER_DLY_CYC);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= TMR_RESET;
    end else begin
      q <= d;
    end
  end

  assign lnk.done = q.done;

  a_delay_length: assert property (
    @(posedge core_clk) disable iff (!arst_n || clear)
    (lnk.start && !q.busy) |-> ##41 q.done)
    else $error("transfer delay not 2 us");
endmodule // xfer_delay
